// >>> bench/bridge_model.sv
// Behavioural bridge that logs error reports and grants pending-state changes.
// Assumes the controller drives its pins from clk_sys_i.
`timescale 1ns/1ns

// ==========================================================================
// Bridge model
// ==========================================================================
module bridge_model (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [3:0] dly_i,
	input wire logic [6:0] flags_i,
	input wire logic pf_i,
	input wire logic virt_i,
	input wire logic [10:0] ofs_i,
	input wire logic [127:0] hdr_i,
	input wire logic chg_i,
	input wire logic st_i,
	output logic grant_o
);
	logic [3:0] cnt;
	logic [6:0] last_flags;
	logic last_pf, last_virt, vf_state;
	logic [10:0] last_ofs;
	logic [127:0] last_hdr;
	int n_log, n_grant;
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{cnt, last_flags, last_pf, last_virt, vf_state, last_ofs, last_hdr, grant_o} <= '0;
			n_log <= 0;
			n_grant <= 0;
		end else begin
			if (flags_i != 7'h00) begin
				n_log <= n_log + 1;
				last_flags <= flags_i;
				last_pf <= pf_i;
				last_virt <= virt_i;
				last_ofs <= virt_i ? ofs_i : 11'h000;
				last_hdr <= flags_i[6] ? hdr_i : 128'h0;
			end
			grant_o <= 1'b0;
			cnt <= 4'h0;
			// A slow grant makes the controller hold its request for several cycles.
			if (chg_i && !grant_o) begin
				cnt <= cnt + 4'h1;
				if (cnt >= dly_i) begin
					grant_o <= 1'b1;
					n_grant <= n_grant + 1;
					vf_state <= st_i;
				end
			end
		end
	end
endmodule : bridge_model

// >>> bench/cpl_err_checker_sva.sv
// Checker for the completion error reporting controller.
// Assumes it is bound to cpl_err_reporter and sees only its ports.
`timescale 1ns/1ns

// ==========================================================================
// Port checks
// ==========================================================================
module cpl_err_checker
	import err_report_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic rep_valid_i,
	input wire logic [1:0] rep_kind_i,
	input wire logic rep_log_hdr_i,
	input wire logic [HDR_W-1:0] rep_hdr_i,
	input wire logic [PF_IDX_W-1:0] rep_pf_i,
	input wire logic rep_virtual_i,
	input wire logic [VF_OFS_W-1:0] rep_vf_offset_i,
	input wire logic rep_refused_o,
	input wire logic np_issue_i,
	input wire logic [PF_IDX_W-1:0] np_issue_pf_i,
	input wire logic cpl_done_i,
	input wire logic [PF_IDX_W-1:0] cpl_done_pf_i,
	input wire logic [FLAG_W-1:0] err_flags_o,
	input wire logic [PF_IDX_W-1:0] err_phys_func_index_o,
	input wire logic err_from_virtual_func_o,
	input wire logic [VF_OFS_W-1:0] err_virt_func_offset_o,
	input wire logic [HDR_W-1:0] err_tlp_header_o,
	input wire logic [PF_COUNT-1:0] phys_func_pending_flags_o,
	input wire logic virt_func_pending_change_o,
	input wire logic virt_func_pending_state_o,
	input wire logic virt_func_pending_change_grant_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	logic ok;
	assign ok = rep_valid_i && (!rep_virtual_i || rep_vf_offset_i < VF_PER_PF);
	property p_flags; ok |=> err_flags_o == {$past(rep_log_hdr_i), 4'h1 << $past(rep_kind_i), 2'b00}; endproperty
	a_flags: assert property (p_flags) else $error("flag pattern wrong");
	property p_idle; !ok |=> err_flags_o == 7'h00; endproperty
	a_idle: assert property (p_idle) else $error("flags without report");
	property p_id; ok |=> err_phys_func_index_o == $past(rep_pf_i) && err_from_virtual_func_o == $past(rep_virtual_i)
		&& err_virt_func_offset_o == ($past(rep_virtual_i) ? $past(rep_vf_offset_i) : 11'h000); endproperty
	a_id: assert property (p_id) else $error("function identity wrong");
	property p_ref; rep_valid_i && rep_virtual_i && rep_vf_offset_i >= VF_PER_PF |=> rep_refused_o && err_flags_o == 7'h00;
	endproperty
	a_ref: assert property (p_ref) else $error("bad offset not refused");
	property p_hdr; ok && rep_log_hdr_i |=> err_tlp_header_o == $past(rep_hdr_i); endproperty
	a_hdr: assert property (p_hdr) else $error("header wrong");
	property p_hold; virt_func_pending_change_o && !virt_func_pending_change_grant_i
		|=> virt_func_pending_change_o && $stable(virt_func_pending_state_o); endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");
	property p_drop; virt_func_pending_change_o && virt_func_pending_change_grant_i |=> !virt_func_pending_change_o;
	endproperty
	a_drop: assert property (p_drop) else $error("request kept after grant");
	property p_pend; np_issue_i && !(cpl_done_i && cpl_done_pf_i == np_issue_pf_i)
		|=> phys_func_pending_flags_o[$past(np_issue_pf_i)]; endproperty
	a_pend: assert property (p_pend) else $error("pending flag missing");
	c_virt: cover property (ok && rep_virtual_i);
	c_ref: cover property (rep_refused_o);
	c_grant: cover property (virt_func_pending_change_o && virt_func_pending_change_grant_i);
endmodule : cpl_err_checker

bind cpl_err_reporter cpl_err_checker u_chk (
	.clk_sys_i(clk_sys_i),
	.arst_n_i(arst_n_i),
	.rep_valid_i(rep_valid_i),
	.rep_kind_i(rep_kind_i),
	.rep_log_hdr_i(rep_log_hdr_i),
	.rep_hdr_i(rep_hdr_i),
	.rep_pf_i(rep_pf_i),
	.rep_virtual_i(rep_virtual_i),
	.rep_vf_offset_i(rep_vf_offset_i),
	.rep_refused_o(rep_refused_o),
	.np_issue_i(np_issue_i),
	.np_issue_pf_i(np_issue_pf_i),
	.cpl_done_i(cpl_done_i),
	.cpl_done_pf_i(cpl_done_pf_i),
	.err_flags_o(err_flags_o),
	.err_phys_func_index_o(err_phys_func_index_o),
	.err_from_virtual_func_o(err_from_virtual_func_o),
	.err_virt_func_offset_o(err_virt_func_offset_o),
	.err_tlp_header_o(err_tlp_header_o),
	.phys_func_pending_flags_o(phys_func_pending_flags_o),
	.virt_func_pending_change_o(virt_func_pending_change_o),
	.virt_func_pending_state_o(virt_func_pending_state_o),
	.virt_func_pending_change_grant_i(virt_func_pending_change_grant_i)
);

// >>> bench/tb.sv
// Self-checking testbench for the completion error reporting controller.
// Assumes the package, the carrier interface and both design modules are compiled first.
`timescale 1ns/1ns

// ==========================================================================
// Bench top
// ==========================================================================
module tb;
	import err_report_pkg::*;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, rep_valid_i = 1'b0, rep_log_hdr_i = 1'b0, rep_pf_i = 1'b0;
	logic rep_virtual_i = 1'b0, np_issue_i = 1'b0, np_issue_pf_i = 1'b0, cpl_done_i = 1'b0, cpl_done_pf_i = 1'b0;
	logic vf_change_i = 1'b0, vf_pending_i = 1'b0, virt_func_pending_change_grant_i;
	logic [1:0] rep_kind_i = 2'h0;
	logic [127:0] rep_hdr_i = 128'h0, err_tlp_header_o;
	logic [10:0] rep_vf_offset_i = 11'h000, err_virt_func_offset_o;
	logic [3:0] dly = 4'h0;
	logic rep_refused_o, vf_change_busy_o, err_phys_func_index_o, err_from_virtual_func_o;
	logic virt_func_pending_change_o, virt_func_pending_state_o;
	logic [6:0] err_flags_o;
	logic [1:0] phys_func_pending_flags_o;
	int n_fail = 0, compares = 0;

	cpl_err_reporter u_dut (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.rep_valid_i(rep_valid_i),
		.rep_kind_i(rep_kind_i),
		.rep_log_hdr_i(rep_log_hdr_i),
		.rep_hdr_i(rep_hdr_i),
		.rep_pf_i(rep_pf_i),
		.rep_virtual_i(rep_virtual_i),
		.rep_vf_offset_i(rep_vf_offset_i),
		.rep_refused_o(rep_refused_o),
		.np_issue_i(np_issue_i),
		.np_issue_pf_i(np_issue_pf_i),
		.cpl_done_i(cpl_done_i),
		.cpl_done_pf_i(cpl_done_pf_i),
		.vf_change_i(vf_change_i),
		.vf_pending_i(vf_pending_i),
		.vf_change_busy_o(vf_change_busy_o),
		.err_flags_o(err_flags_o),
		.err_phys_func_index_o(err_phys_func_index_o),
		.err_from_virtual_func_o(err_from_virtual_func_o),
		.err_virt_func_offset_o(err_virt_func_offset_o),
		.err_tlp_header_o(err_tlp_header_o),
		.phys_func_pending_flags_o(phys_func_pending_flags_o),
		.virt_func_pending_change_o(virt_func_pending_change_o),
		.virt_func_pending_state_o(virt_func_pending_state_o),
		.virt_func_pending_change_grant_i(virt_func_pending_change_grant_i)
	);
	bridge_model m (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .dly_i(dly), .flags_i(err_flags_o),
		.pf_i(err_phys_func_index_o), .virt_i(err_from_virtual_func_o), .ofs_i(err_virt_func_offset_o),
		.hdr_i(err_tlp_header_o), .chg_i(virt_func_pending_change_o), .st_i(virt_func_pending_state_o),
		.grant_o(virt_func_pending_change_grant_i));

	always #5 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("n_fail=%0d compares=%0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	task automatic rep(input logic [1:0] k, input logic v, input logic [10:0] o, input logic l, input logic p);
		int n;
		logic ok;
		n = m.n_log;
		ok = !(v && o >= VF_PER_PF);
		@(posedge clk_sys_i);
		{rep_valid_i, rep_kind_i, rep_virtual_i, rep_vf_offset_i, rep_log_hdr_i, rep_pf_i} <= {1'b1, k, v, o, l, p};
		rep_hdr_i <= {8{5'h00, o}};
		@(posedge clk_sys_i);
		rep_valid_i <= 1'b0;
		#1 chk(rep_refused_o, !ok);
		@(posedge clk_sys_i);
		#1 chk(m.n_log, n + ok);
		if (ok) begin
			chk(m.last_flags, {l, 4'h1 << k, 2'b00});
			chk({m.last_pf, m.last_virt, m.last_ofs}, {p, v, v ? o : 11'h000});
			chk(m.last_hdr, l ? {8{5'h00, o}} : 128'h0);
		end
	endtask : rep

	task automatic back_to_back;
		int n;
		n = m.n_log;
		@(posedge clk_sys_i);
		{rep_valid_i, rep_kind_i, rep_virtual_i} <= {1'b1, 2'h2, 1'b0};
		@(posedge clk_sys_i);
		rep_kind_i <= 2'h3;
		@(posedge clk_sys_i);
		rep_valid_i <= 1'b0;
		@(posedge clk_sys_i);
		#1 chk(m.n_log, n + 2);
		chk(m.last_flags, 7'h20);
	endtask : back_to_back

	task automatic pend(input logic i, input logic ip, input logic d, input logic dp, input logic [1:0] exp);
		@(posedge clk_sys_i);
		{np_issue_i, np_issue_pf_i, cpl_done_i, cpl_done_pf_i} <= {i, ip, d, dp};
		@(posedge clk_sys_i);
		{np_issue_i, cpl_done_i} <= 2'b00;
		#1 chk(phys_func_pending_flags_o, exp);
	endtask : pend

	task automatic vf(input logic st, input logic [3:0] d);
		int n;
		n = m.n_grant;
		dly <= d;
		@(posedge clk_sys_i);
		{vf_change_i, vf_pending_i} <= {1'b1, st};
		@(posedge clk_sys_i);
		vf_change_i <= 1'b0;
		#1 chk(vf_change_busy_o, 1'b1);
		for (int i = 0; i < 40 && m.n_grant == n; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		if (m.n_grant == n) begin
			n_fail++;
			end_of_test();
		end else begin
			chk(m.vf_state, st);
		end
	endtask : vf

	initial begin
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		#1 chk({err_flags_o, virt_func_pending_change_o, phys_func_pending_flags_o}, 128'h0);
		for (int k = 0; k < 4; k++) rep(2'(k), k[0], 11'(k * 20), k < 2, k[1]);
		rep(2'h2, 1'b1, VF_PER_PF - 11'h001, 1'b1, 1'b0);
		rep(2'h3, 1'b1, VF_PER_PF, 1'b1, 1'b1);
		rep(2'h1, 1'b0, 11'h7ff, 1'b0, 1'b1);
		back_to_back();
		pend(1'b1, 1'b1, 1'b0, 1'b0, 2'b10);
		pend(1'b1, 1'b0, 1'b1, 1'b1, 2'b01);
		pend(1'b0, 1'b0, 1'b1, 1'b0, 2'b00);
		pend(1'b0, 1'b0, 1'b1, 1'b1, 2'b00);
		vf(1'b1, 4'h6);
		vf(1'b0, 4'h0);
		repeat (3) @(posedge clk_sys_i);
		#1 chk({vf_change_busy_o, virt_func_pending_change_o}, 2'b00);
		end_of_test();
	end
endmodule : tb

// >>> hdl/cpl_err_reporter.sv
// Application-side controller that reports completion errors and pending state to the bridge.
// Assumes the bridge samples every output on the rising edge of clk_sys_i.
// Assumes user inputs are synchronous to clk_sys_i and reports arrive as single-cycle pulses.
`timescale 1ns/1ns

module cpl_err_reporter
	import err_report_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic rep_valid_i,
	input wire logic [1:0] rep_kind_i,
	input wire logic rep_log_hdr_i,
	input wire logic [HDR_W-1:0] rep_hdr_i,
	input wire logic [PF_IDX_W-1:0] rep_pf_i,
	input wire logic rep_virtual_i,
	input wire logic [VF_OFS_W-1:0] rep_vf_offset_i,
	output logic rep_refused_o,
	input wire logic np_issue_i,
	input wire logic [PF_IDX_W-1:0] np_issue_pf_i,
	input wire logic cpl_done_i,
	input wire logic [PF_IDX_W-1:0] cpl_done_pf_i,
	input wire logic vf_change_i,
	input wire logic vf_pending_i,
	output logic vf_change_busy_o,
	output logic [FLAG_W-1:0] err_flags_o,
	output logic [PF_IDX_W-1:0] err_phys_func_index_o,
	output logic err_from_virtual_func_o,
	output logic [VF_OFS_W-1:0] err_virt_func_offset_o,
	output logic [HDR_W-1:0] err_tlp_header_o,
	output logic [PF_COUNT-1:0] phys_func_pending_flags_o,
	output logic virt_func_pending_change_o,
	output logic virt_func_pending_state_o,
	input wire logic virt_func_pending_change_grant_i
);
	// ======================================================================
	// Report acceptance
	// ======================================================================
	// An out-of-range virtual offset is turned away here rather than sent:
	// the bridge would attribute it to a function that does not exist.
	logic offset_bad;
	logic rep_take;
	logic [FLAG_W-1:0] next_flags;

	assign offset_bad = rep_virtual_i && (rep_vf_offset_i >= VF_PER_PF);
	assign rep_take = rep_valid_i && !offset_bad;

	always_comb begin
		next_flags = FLAGS_RST;
		if (rep_take) begin
			// Each kind owns one flag bit; the log bit rides along with it.
			case (err_kind_t'(rep_kind_i))
				KIND_ABORT: begin
					next_flags[FLAG_ABORT] = 1'b1;
				end
				KIND_UNEXP_CPL: begin
					next_flags[FLAG_UNEXP_CPL] = 1'b1;
				end
				KIND_UR_POSTED: begin
					next_flags[FLAG_UR_POSTED] = 1'b1;
				end
				KIND_UR_NONPOSTED: begin
					next_flags[FLAG_UR_NONPOSTED] = 1'b1;
				end
				default: begin
					// Unreachable with a two-bit kind; keeps the kind flags quiet.
					next_flags = FLAGS_RST;
				end
			endcase
			next_flags[FLAG_LOG_HDR] = rep_log_hdr_i;
		end
	end

	// ======================================================================
	// Error flags
	// ======================================================================
	// Flags are rebuilt every cycle, so each report shows for one cycle only
	// and back-to-back reports give back-to-back pulses.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_flags_o <= FLAGS_RST;
		end else begin
			err_flags_o <= next_flags;
		end
	end

	// ======================================================================
	// Refused reports
	// ======================================================================
	// The pulse tells the user that the report never reached the bridge.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rep_refused_o <= 1'b0;
		end else begin
			rep_refused_o <= rep_valid_i && offset_bad;
		end
	end

	// ======================================================================
	// Function identity and header
	// ======================================================================
	// Identity and header move in the same edge as the flags, so the bridge
	// sees one coherent report whenever a flag is high.
	// The index holds between reports; the bridge reads it only with a flag.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_phys_func_index_o <= '0;
		end else if (rep_take) begin
			err_phys_func_index_o <= rep_pf_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_from_virtual_func_o <= 1'b0;
		end else begin
			err_from_virtual_func_o <= rep_take && rep_virtual_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_virt_func_offset_o <= VF_OFS_RST;
		end else if (rep_take && rep_virtual_i) begin
			err_virt_func_offset_o <= rep_vf_offset_i;
		end else begin
			// A physical report carries a zero offset; the bridge ignores it.
			err_virt_func_offset_o <= VF_OFS_RST;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_tlp_header_o <= HDR_RST;
		end else if (rep_take && rep_log_hdr_i) begin
			err_tlp_header_o <= rep_hdr_i;
		end else begin
			err_tlp_header_o <= HDR_RST;
		end
	end

	// ======================================================================
	// Outstanding non-posted requests per physical function
	// ======================================================================
	// The counter saturates; a user that overruns it keeps the flag high,
	// which errs toward reporting pending rather than losing it.
	genvar gi;
	generate
		for (gi = 0; gi < PF_COUNT; gi++) begin : g_pf
			logic [NP_CNT_W-1:0] count;
			logic [NP_CNT_W-1:0] next_count;
			logic inc;
			logic dec;

			assign inc = np_issue_i && (np_issue_pf_i == PF_IDX_W'(gi)) && (count != NP_CNT_MAX);
			assign dec = cpl_done_i && (cpl_done_pf_i == PF_IDX_W'(gi)) && (count != NP_CNT_RST);

			always_comb begin
				next_count = count;
				if (inc && !dec) begin
					next_count = count + NP_CNT_W'(1);
				end else if (dec && !inc) begin
					next_count = count - NP_CNT_W'(1);
				end
			end

			always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					count <= NP_CNT_RST;
				end else begin
					count <= next_count;
				end
			end

			always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					phys_func_pending_flags_o[gi] <= 1'b0;
				end else begin
					// Taken from the next count so the flag moves with the counting edge.
					phys_func_pending_flags_o[gi] <= (next_count != NP_CNT_RST);
				end
			end
		end
	endgenerate

	// ======================================================================
	// Virtual function pending-state changes
	// ======================================================================
	// The user reports each change once; the engine holds the request until
	// granted and coalesces changes that arrive meanwhile.
	pend_change_if change_link();

	assign change_link.valid = vf_change_i;
	assign change_link.state = vf_pending_i;
	assign vf_change_busy_o = change_link.busy;

	vf_pending_handshake u_handshake (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.link(change_link.sink),
		.virt_func_pending_change_grant_i(virt_func_pending_change_grant_i),
		.virt_func_pending_change_o(virt_func_pending_change_o),
		.virt_func_pending_state_o(virt_func_pending_state_o)
	);
endmodule : cpl_err_reporter

// >>> hdl/err_report_pkg.sv
// Shared constants and types for the completion error reporting controller.
// Assumes one application clock and an active low asynchronous reset.

// ==========================================================================
// Widths and counts
// ==========================================================================
package err_report_pkg;
	localparam int PF_COUNT = 2;
	localparam int PF_IDX_W = 1;
	localparam int VF_OFS_W = 11;
	localparam int HDR_W = 128;
	localparam int FLAG_W = 7;
	localparam int NP_CNT_W = 8;

	// Virtual functions attached to each physical function; adjust per build.
	localparam logic [10:0] VF_PER_PF = 11'h040;

	// ======================================================================
	// Error flag bit positions
	// ======================================================================
	localparam int FLAG_ABORT = 2;
	localparam int FLAG_UNEXP_CPL = 3;
	localparam int FLAG_UR_POSTED = 4;
	localparam int FLAG_UR_NONPOSTED = 5;
	localparam int FLAG_LOG_HDR = 6;

	// ======================================================================
	// Reset values and limits
	// ======================================================================
	localparam logic [6:0] FLAGS_RST = 7'h00;
	localparam logic [7:0] NP_CNT_RST = 8'h00;
	localparam logic [7:0] NP_CNT_MAX = 8'hff;
	localparam logic [10:0] VF_OFS_RST = 11'h000;
	localparam logic [127:0] HDR_RST = 128'h0;

	// ======================================================================
	// Types
	// ======================================================================
	typedef enum logic [1:0] {
		KIND_ABORT,
		KIND_UNEXP_CPL,
		KIND_UR_POSTED,
		KIND_UR_NONPOSTED
	} err_kind_t;
endpackage : err_report_pkg

// >>> hdl/pend_change_if.sv
// Carries one pending-state change from the report controller to the handshake engine.
// Assumes both ends share one clock.
`timescale 1ns/1ns

// ==========================================================================
// Change request carrier
// ==========================================================================
interface pend_change_if;
	logic valid;
	logic state;
	logic busy;

	modport source (output valid, output state, input busy);
	modport sink (input valid, input state, output busy);
endinterface : pend_change_if

// >>> hdl/vf_pending_handshake.sv
// Request and grant handshake that reports a virtual function pending-state change.
// Assumes the bridge answers the held request with a grant level on the same clock.
`timescale 1ns/1ns

module vf_pending_handshake
	import err_report_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	pend_change_if.sink link,
	input wire logic virt_func_pending_change_grant_i,
	output logic virt_func_pending_change_o,
	output logic virt_func_pending_state_o
);
	typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_GAP} hs_state_t;

	hs_state_t fsm;
	logic queued;
	logic queued_state;
	logic busy;

	// ======================================================================
	// Sequencer
	// ======================================================================
	// A change seen while a request is in flight is kept, newest value wins,
	// and launched after a two-cycle gap so the bridge sees a fresh edge.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fsm <= HS_IDLE;
			virt_func_pending_change_o <= 1'b0;
			virt_func_pending_state_o <= 1'b0;
		end else begin
			case (fsm)
				HS_IDLE: begin
					if (link.valid || queued) begin
						virt_func_pending_change_o <= 1'b1;
						virt_func_pending_state_o <= link.valid ? link.state : queued_state;
						fsm <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (virt_func_pending_change_grant_i) begin
						virt_func_pending_change_o <= 1'b0;
						fsm <= HS_GAP;
					end
				end
				HS_GAP: begin
					fsm <= HS_IDLE;
				end
				default: begin
					fsm <= HS_IDLE;
					virt_func_pending_change_o <= 1'b0;
				end
			endcase
		end
	end

	// ======================================================================
	// Change held back during a request
	// ======================================================================
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			queued <= 1'b0;
			queued_state <= 1'b0;
		end else if (fsm == HS_IDLE) begin
			queued <= 1'b0;
		end else if (link.valid) begin
			queued <= 1'b1;
			queued_state <= link.state;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy <= 1'b0;
		end else begin
			busy <= (fsm != HS_IDLE) || link.valid || queued;
		end
	end

	assign link.busy = busy;
endmodule : vf_pending_handshake
